// File: src/crs_pkg.sv
// Constants of the CPU register set: system register numbers, field layout, reset values.
// Assumes the pipeline and interrupt logic share the single CPU clock.

package crs_pkg;

    localparam int WORD_W = 32;
    localparam int GPR_COUNT = 32;
    localparam int GPR_IDX_W = 5;
    localparam int SYSNUM_W = 5;
    localparam int PC_W = 26;
    localparam int STATUS_W = 8;

    localparam logic [4:0] GPR_ZERO = 5'h00;
    localparam logic [4:0] GPR_ELEMENT_BASE = 5'h1e;

    localparam logic [4:0] SR_INTERRUPT_PC_SAVE = 5'h00;
    localparam logic [4:0] SR_INTERRUPT_STATUS_SAVE = 5'h01;
    localparam logic [4:0] SR_NMI_PC_SAVE = 5'h02;
    localparam logic [4:0] SR_NMI_STATUS_SAVE = 5'h03;
    localparam logic [4:0] SR_EXCEPTION_CAUSE = 5'h04;
    localparam logic [4:0] SR_PROGRAM_STATUS_WORD = 5'h05;
    localparam logic [4:0] SR_TABLE_CALL_PC_SAVE = 5'h10;
    localparam logic [4:0] SR_TABLE_CALL_STATUS_SAVE = 5'h11;
    localparam logic [4:0] SR_DEBUG_PC_SAVE = 5'h12;
    localparam logic [4:0] SR_DEBUG_STATUS_SAVE = 5'h13;
    localparam logic [4:0] SR_TABLE_CALL_BASE = 5'h14;

    localparam int NMI_SERVICING_BIT = 7;
    localparam int INT_DISABLE_BIT = 5;

    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0020;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_MASK = 32'h03ff_fffe;
    localparam logic [31:0] STATUS_MASK = 32'h0000_00ff;

    typedef enum logic [1:0] {
        CRS_EV_NONE = 2'b00,
        CRS_EV_MASKABLE = 2'b01,
        CRS_EV_NMI = 2'b10,
        CRS_EV_DEBUG = 2'b11
    } crs_event_t;

endpackage

// File: src/crs_gpr_bank.sv
// General-purpose register bank: thirty-two words, two read ports, one write port.
// Assumes writes come from the pipeline write-back stage on the CPU clock.
`timescale 1ns/100ps

module crs_gpr_bank #(
    parameter int COUNT = crs_pkg::GPR_COUNT
) (
    input wire logic ref_clk, // CPU clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic wrEn, // Write strobe
    input wire logic [crs_pkg::GPR_IDX_W-1:0] wrIdx, // Write index
    input wire logic [crs_pkg::WORD_W-1:0] wrData, // Write data
    input wire logic [crs_pkg::GPR_IDX_W-1:0] rdIdxA, // Read index A
    input wire logic [crs_pkg::GPR_IDX_W-1:0] rdIdxB, // Read index B
    output logic [crs_pkg::WORD_W-1:0] rdDataA, // Registered read data A
    output logic [crs_pkg::WORD_W-1:0] rdDataB // Registered read data B
);

    logic [crs_pkg::WORD_W-1:0] gpr_r [COUNT];

    // ----------------------------------------
    // Storage; entry zero is never written
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < COUNT; gi++) begin : g_gpr
            // Entry zero stays in its reset state, so every entry has one procedural driver
            always_ff @(posedge ref_clk) begin
                if (sys_rst || gi == 0) begin
                    gpr_r[gi] <= crs_pkg::WORD_RESET;
                end else if (wrEn && wrIdx == crs_pkg::GPR_IDX_W'(gi)) begin
                    gpr_r[gi] <= wrData;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdDataA <= crs_pkg::WORD_RESET;
            rdDataB <= crs_pkg::WORD_RESET;
        end else begin
            rdDataA <= gpr_r[rdIdxA];
            rdDataB <= gpr_r[rdIdxB];
        end
    end

endmodule

// File: src/crs_register_set.sv
// CPU register set top: general-purpose bank, program counter and system registers.
// Assumes the pipeline presents one request per cycle and that event strobes are one-cycle pulses.
`timescale 1ns/100ps

module crs_register_set (
    input wire logic ref_clk, // CPU clock, 20 MHz
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic gprWrEn, // GPR write strobe
    input wire logic [4:0] gprWrIdx, // GPR write index
    input wire logic [31:0] gprWrData, // GPR write data
    input wire logic [4:0] gprRdIdxA, // GPR read index A
    input wire logic [4:0] gprRdIdxB, // GPR read index B
    input wire logic shortMemAccess, // Short load or short store: port A reads the base pointer
    output logic [31:0] gprRdDataA, // GPR read data A
    output logic [31:0] gprRdDataB, // GPR read data B
    input wire logic pcLoad, // Load PC from branch target
    input wire logic [31:0] pcLoadValue, // Branch target
    input wire logic pcIncr, // Step PC
    input wire logic [2:0] pcIncrStep, // Step size in bytes
    output logic [31:0] pcValue, // Program counter
    input wire logic [31:0] nextInstrPc, // Address of the following instruction
    input wire logic psWrEn, // Pipeline flag update of the status word
    input wire logic [7:0] psWrData, // New flags
    input wire logic sysWrEn, // Load-system-register strobe
    input wire logic sysRdEn, // Store-system-register strobe
    input wire logic [4:0] sysNum, // System register number
    input wire logic [31:0] sysWrData, // Load-system-register data
    output logic [31:0] sysRdData, // Store-system-register data
    output logic sysRdValid, // Read answer strobe
    output logic sysAccessDenied, // Access to a prohibited number
    input wire logic maskableAccept, // Software exception or maskable interrupt accepted
    input wire logic nmiAccept, // NMI pin or watchdog NMI accepted
    input wire logic debugTrapAccept, // Debug trap or illegal opcode trap
    input wire logic tableCallExec, // Table-call instruction executes
    input wire logic [31:0] causeCode, // Exception code of the accepted source
    input wire logic returnFromInterrupt, // Return-from-interrupt executes
    input wire logic debugReturn, // Debug-return executes
    output logic [31:0] statusWord, // Current status word
    output logic debugWindow // Debug save registers accessible
);

    logic [31:0] pc_r, pc_nxt;
    logic [31:0] psw_r, psw_nxt;
    logic [31:0] intPc_r, intPc_nxt;
    logic [31:0] intPs_r, intPs_nxt;
    logic [31:0] nmiPc_r, nmiPc_nxt;
    logic [31:0] nmiPs_r, nmiPs_nxt;
    logic [31:0] cause_r, cause_nxt;
    logic [31:0] tcPc_r, tcPc_nxt;
    logic [31:0] tcPs_r, tcPs_nxt;
    logic [31:0] debug_pc_save_r, debug_pc_save_nxt;
    logic [31:0] dbPs_r, dbPs_nxt;
    logic [31:0] tcBase_r, tcBase_nxt;
    logic dbWin_r, dbWin_nxt;
    logic [31:0] sysRd_r;
    logic sysRdValid_r;
    logic denied_r;
    logic [4:0] gprIdxA;
    crs_pkg::crs_event_t ev;

    // ----------------------------------------
    // General-purpose registers
    // ----------------------------------------
    // Short accesses always read the base pointer on port A
    assign gprIdxA = shortMemAccess ? crs_pkg::GPR_ELEMENT_BASE : gprRdIdxA;

    crs_gpr_bank #(
        .COUNT(crs_pkg::GPR_COUNT)
    ) i_crs_gpr_bank (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wrEn(gprWrEn),
        .wrIdx(gprWrIdx),
        .wrData(gprWrData),
        .rdIdxA(gprIdxA),
        .rdIdxB(gprRdIdxB),
        .rdDataA(gprRdDataA),
        .rdDataB(gprRdDataB)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire selIntPc = sysNum == crs_pkg::SR_INTERRUPT_PC_SAVE;
    wire selIntPs = sysNum == crs_pkg::SR_INTERRUPT_STATUS_SAVE;
    wire selNmiPc = sysNum == crs_pkg::SR_NMI_PC_SAVE;
    wire selNmiPs = sysNum == crs_pkg::SR_NMI_STATUS_SAVE;
    wire selCause = sysNum == crs_pkg::SR_EXCEPTION_CAUSE;
    wire selPsw = sysNum == crs_pkg::SR_PROGRAM_STATUS_WORD;
    wire selTcPc = sysNum == crs_pkg::SR_TABLE_CALL_PC_SAVE;
    wire selTcPs = sysNum == crs_pkg::SR_TABLE_CALL_STATUS_SAVE;
    wire selDbPc = sysNum == crs_pkg::SR_DEBUG_PC_SAVE;
    wire selDbPs = sysNum == crs_pkg::SR_DEBUG_STATUS_SAVE;
    wire selTcBase = sysNum == crs_pkg::SR_TABLE_CALL_BASE;
    wire selDebug = selDbPc | selDbPs;
    wire selKnown = selIntPc | selIntPs | selNmiPc | selNmiPs | selCause | selPsw |
                    selTcPc | selTcPs | selDebug | selTcBase;
    // Reserved numbers and debug saves outside the trap window are refused
    // The window opens after the trap cycle, so a request in that cycle is refused
    wire accessOk = selKnown & (~selDebug | dbWin_r);
    wire wrOk = sysWrEn & accessOk;
    wire rdOk = sysRdEn & accessOk;
    // NMI flag picks the pair that a return restores
    wire npSet = psw_r[crs_pkg::NMI_SERVICING_BIT];

    // ----------------------------------------
    // Events and returns
    // ----------------------------------------
    // Event priority: NMI over debug trap over maskable
    assign ev = nmiAccept ? crs_pkg::CRS_EV_NMI :
                debugTrapAccept ? crs_pkg::CRS_EV_DEBUG :
                maskableAccept ? crs_pkg::CRS_EV_MASKABLE : crs_pkg::CRS_EV_NONE;

    wire [31:0] pcEven = nextInstrPc & crs_pkg::PC_MASK;
    wire [31:0] psSnap = psw_r & crs_pkg::STATUS_MASK;
    wire [31:0] retPc = npSet ? nmiPc_r : intPc_r;
    wire [31:0] retPs = npSet ? nmiPs_r : intPs_r;
    wire [25:0] pcStep = pc_r[25:0] + {23'h00_0000, pcIncrStep};

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [31:0] rdMux = selIntPc ? intPc_r :
                        selIntPs ? intPs_r :
                        selNmiPc ? nmiPc_r :
                        selNmiPs ? nmiPs_r :
                        selCause ? cause_r :
                        selPsw ? psw_r :
                        selTcPc ? tcPc_r :
                        selTcPs ? tcPs_r :
                        selDbPc ? debug_pc_save_r :
                        selDbPs ? dbPs_r :
                        selTcBase ? tcBase_r : crs_pkg::WORD_RESET;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        pc_nxt = pc_r;
        psw_nxt = psw_r;
        intPc_nxt = intPc_r;
        intPs_nxt = intPs_r;
        nmiPc_nxt = nmiPc_r;
        nmiPs_nxt = nmiPs_r;
        cause_nxt = cause_r;
        tcPc_nxt = tcPc_r;
        tcPs_nxt = tcPs_r;
        debug_pc_save_nxt = debug_pc_save_r;
        dbPs_nxt = dbPs_r;
        tcBase_nxt = tcBase_r;
        dbWin_nxt = dbWin_r;

        // Flag updates and PC sequencing from the pipeline
        if (psWrEn) begin
            psw_nxt = {24'h00_0000, psWrData};
        end
        if (pcLoad) begin
            pc_nxt = pcLoadValue;
        end else if (pcIncr) begin
            pc_nxt = {6'h00, pcStep};
        end

        // Software writes land at once, visible to the next instruction
        if (wrOk) begin
            if (selIntPc) intPc_nxt = sysWrData;
            if (selIntPs) intPs_nxt = sysWrData;
            if (selNmiPc) nmiPc_nxt = sysWrData;
            if (selNmiPs) nmiPs_nxt = sysWrData;
            if (selPsw) psw_nxt = sysWrData;
            if (selTcPc) tcPc_nxt = sysWrData;
            if (selTcPs) tcPs_nxt = sysWrData;
            if (selDbPc) debug_pc_save_nxt = sysWrData;
            if (selDbPs) dbPs_nxt = sysWrData;
            if (selTcBase) tcBase_nxt = sysWrData;
            // Cause register has no write path
        end

        // Table calls save the same next address as events
        if (tableCallExec) begin
            tcPc_nxt = pcEven;
            tcPs_nxt = psSnap;
        end

        // Returns restore the chosen pair; bit 0 of the saved PC drops out
        if (returnFromInterrupt) begin
            pc_nxt = retPc;
            psw_nxt = retPs;
        end
        if (debugReturn) begin
            pc_nxt = debug_pc_save_r;
            psw_nxt = dbPs_r;
            dbWin_nxt = 1'b0;
        end

        // Accepted events override save and cause writes in the same cycle; other status and PC updates still land
        // One event at a time keeps two saves out of one cycle
        unique case (ev)
            crs_pkg::CRS_EV_NONE: begin
            end
            crs_pkg::CRS_EV_MASKABLE: begin
                intPc_nxt = pcEven;
                intPs_nxt = psSnap;
                cause_nxt = causeCode;
                psw_nxt[crs_pkg::INT_DISABLE_BIT] = 1'b1;
            end
            crs_pkg::CRS_EV_NMI: begin
                nmiPc_nxt = pcEven;
                nmiPs_nxt = psSnap;
                cause_nxt = causeCode;
                psw_nxt[crs_pkg::NMI_SERVICING_BIT] = 1'b1;
                psw_nxt[crs_pkg::INT_DISABLE_BIT] = 1'b1;
            end
            crs_pkg::CRS_EV_DEBUG: begin
                debug_pc_save_nxt = pcEven;
                dbPs_nxt = psSnap;
                cause_nxt = causeCode;
                dbWin_nxt = 1'b1;
            end
        endcase

        // Reserved bits are cleared on every path into the PC, status and save registers; cause and table-call base keep all 32 bits
        pc_nxt = pc_nxt & crs_pkg::PC_MASK;
        psw_nxt = psw_nxt & crs_pkg::STATUS_MASK;
        intPc_nxt = intPc_nxt & crs_pkg::PC_MASK;
        nmiPc_nxt = nmiPc_nxt & crs_pkg::PC_MASK;
        tcPc_nxt = tcPc_nxt & crs_pkg::PC_MASK;
        debug_pc_save_nxt = debug_pc_save_nxt & crs_pkg::PC_MASK;
        intPs_nxt = intPs_nxt & crs_pkg::STATUS_MASK;
        nmiPs_nxt = nmiPs_nxt & crs_pkg::STATUS_MASK;
        tcPs_nxt = tcPs_nxt & crs_pkg::STATUS_MASK;
        dbPs_nxt = dbPs_nxt & crs_pkg::STATUS_MASK;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Two blocks only to keep each one short
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pc_r <= crs_pkg::PC_RESET;
            psw_r <= crs_pkg::STATUS_RESET;
            intPc_r <= crs_pkg::WORD_RESET;
            intPs_r <= crs_pkg::WORD_RESET;
            nmiPc_r <= crs_pkg::WORD_RESET;
            nmiPs_r <= crs_pkg::WORD_RESET;
            cause_r <= crs_pkg::WORD_RESET;
        end else begin
            pc_r <= pc_nxt;
            psw_r <= psw_nxt;
            intPc_r <= intPc_nxt;
            intPs_r <= intPs_nxt;
            nmiPc_r <= nmiPc_nxt;
            nmiPs_r <= nmiPs_nxt;
            cause_r <= cause_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tcPc_r <= crs_pkg::WORD_RESET;
            tcPs_r <= crs_pkg::WORD_RESET;
            debug_pc_save_r <= crs_pkg::WORD_RESET;
            dbPs_r <= crs_pkg::WORD_RESET;
            tcBase_r <= crs_pkg::WORD_RESET;
            dbWin_r <= 1'b0;
        end else begin
            tcPc_r <= tcPc_nxt;
            tcPs_r <= tcPs_nxt;
            debug_pc_save_r <= debug_pc_save_nxt;
            dbPs_r <= dbPs_nxt;
            tcBase_r <= tcBase_nxt;
            dbWin_r <= dbWin_nxt;
        end
    end

    // ----------------------------------------
    // Read answer
    // ----------------------------------------
    // Read answer is registered: one cycle after the strobe
    // A refused read answers zero, never stale data
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sysRd_r <= crs_pkg::WORD_RESET;
            sysRdValid_r <= 1'b0;
            denied_r <= 1'b0;
        end else begin
            sysRd_r <= rdOk ? rdMux : crs_pkg::WORD_RESET;
            sysRdValid_r <= sysRdEn;
            denied_r <= (sysRdEn | sysWrEn) & ~accessOk;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign pcValue = pc_r;
    assign statusWord = psw_r;
    assign debugWindow = dbWin_r;
    assign sysRdData = sysRd_r;
    assign sysRdValid = sysRdValid_r;
    assign sysAccessDenied = denied_r;

endmodule

// File: sim/crs_pipe_model.sv
// Pipeline side of the system register port: store and load system register cycles.
// Assumes the register set takes a request at the rising edge and answers one cycle later.
`timescale 1ns/100ps

module crs_pipe_model (
    input wire logic ref_clk, // CPU clock
    input wire logic [31:0] sysRdData, // Read answer
    input wire logic sysAccessDenied, // Refusal strobe
    output logic sysWrEn, // Load strobe
    output logic sysRdEn, // Store strobe
    output logic [4:0] sysNum, // Register number
    output logic [31:0] sysWrData // Load data
);
    initial begin
        sysWrEn = 1'b0;
        sysRdEn = 1'b0;
        sysNum = 5'h1f;
        sysWrData = 32'h0000_0000;
    end

    // Released lines show the inverse so a stale value is never mistaken for a live one
    task sysWr(input logic [4:0] num, input logic [31:0] data);
        @(posedge ref_clk);
        sysWrEn <= 1'b1;
        sysNum <= num;
        sysWrData <= data;
        @(posedge ref_clk);
        sysWrEn <= 1'b0;
        sysNum <= ~num;
        sysWrData <= ~data;
    endtask

    // One request at a time keeps the single save pairs from being overwritten
    task sysRd(input logic [4:0] num, output logic [31:0] data, output logic denied);
        @(posedge ref_clk);
        sysRdEn <= 1'b1;
        sysNum <= num;
        @(posedge ref_clk);
        sysRdEn <= 1'b0;
        sysNum <= ~num;
        @(negedge ref_clk);
        data = sysRdData;
        denied = sysAccessDenied;
    endtask
endmodule

// File: sim/crs_register_set_monitor.sv
// Checker for the register set top: program counter, status word and system port timing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps

module crs_register_set_monitor (
    input wire logic ref_clk, // CPU clock
    input wire logic sys_rst, // Reset
    input wire logic [4:0] gprRdIdxA, // Index A
    input wire logic shortMemAccess, // Base forcing
    input wire logic [31:0] gprRdDataA, // Data A
    input wire logic pcLoad, // PC load
    input wire logic [31:0] pcLoadValue, // Target
    input wire logic pcIncr, // PC step
    input wire logic [2:0] pcIncrStep, // Step size
    input wire logic [31:0] pcValue, // PC
    input wire logic psWrEn, // Flag update
    input wire logic sysWrEn, // Load strobe
    input wire logic sysRdEn, // Store strobe
    input wire logic [4:0] sysNum, // Number
    input wire logic [31:0] sysWrData, // Load data
    input wire logic [31:0] sysRdData, // Read data
    input wire logic sysRdValid, // Read strobe
    input wire logic sysAccessDenied, // Refusal
    input wire logic maskableAccept, // Maskable event
    input wire logic nmiAccept, // NMI event
    input wire logic debugTrapAccept, // Debug event
    input wire logic tableCallExec, // Table call
    input wire logic returnFromInterrupt, // Return
    input wire logic debugReturn, // Debug return
    input wire logic [31:0] statusWord, // Status word
    input wire logic debugWindow // Debug access open
);
    logic quiet;
    assign quiet = !(maskableAccept || nmiAccept || debugTrapAccept || tableCallExec ||
                     returnFromInterrupt || debugReturn);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_takePsw; sysRdEn && sysNum == 5'h05; endsequence
    sequence s_answerPsw; sysRdValid && sysRdData == $past(statusWord); endsequence
    sequence s_nmiTaken; nmiAccept; endsequence

    property p_pcRange; pcValue[31:26] == 6'h00 && !pcValue[0]; endproperty
    property p_pcLoad; pcLoad && quiet |=> pcValue == ($past(pcLoadValue) & 32'h03ff_fffe); endproperty
    property p_pcIncr;
        pcIncr && !pcLoad && quiet |=> pcValue == (($past(pcValue) + $past(pcIncrStep)) & 32'h03ff_fffe);
    endproperty
    property p_zeroReg; gprRdIdxA == 5'h00 && !shortMemAccess |=> gprRdDataA == 32'h0000_0000; endproperty
    property p_readPsw; s_takePsw |=> s_answerPsw; endproperty
    property p_pswWrite;
        sysWrEn && sysNum == 5'h05 && quiet && !psWrEn |=> statusWord == ($past(sysWrData) & 32'h0000_00ff);
    endproperty
    property p_nmiFlag; s_nmiTaken |=> statusWord[7] && statusWord[5]; endproperty
    property p_debugOpen;
        debugTrapAccept && !nmiAccept |=> debugWindow [*2] or (debugWindow ##1 !debugWindow);
    endproperty
    property p_debugDenied;
        (sysRdEn || sysWrEn) && sysNum[4:1] == 4'h9 && !debugWindow && !debugTrapAccept |=> sysAccessDenied;
    endproperty

    a_pcRange: assert property (p_pcRange) else $error("PC outside its 26-bit even range");
    a_pcLoad: assert property (p_pcLoad) else $error("PC load not masked");
    a_pcIncr: assert property (p_pcIncr) else $error("PC step wrong");
    a_zeroReg: assert property (p_zeroReg) else $error("r0 not zero");
    a_readPsw: assert property (p_readPsw) else $error("Status word read answer wrong");
    a_pswWrite: assert property (p_pswWrite) else $error("Status word write not effective");
    a_nmiFlag: assert property (p_nmiFlag) else $error("NMI flag not set");
    a_debugOpen: assert property (p_debugOpen) else $error("Debug window not opened");
    a_debugDenied: assert property (p_debugDenied) else $error("Closed debug access not refused");
endmodule

bind crs_register_set crs_register_set_monitor i_crs_register_set_monitor (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .gprRdIdxA(gprRdIdxA), .shortMemAccess(shortMemAccess),
    .gprRdDataA(gprRdDataA), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .pcIncr(pcIncr),
    .pcIncrStep(pcIncrStep), .pcValue(pcValue), .psWrEn(psWrEn), .sysWrEn(sysWrEn), .sysRdEn(sysRdEn),
    .sysNum(sysNum), .sysWrData(sysWrData), .sysRdData(sysRdData), .sysRdValid(sysRdValid),
    .sysAccessDenied(sysAccessDenied), .maskableAccept(maskableAccept), .nmiAccept(nmiAccept),
    .debugTrapAccept(debugTrapAccept), .tableCallExec(tableCallExec), .returnFromInterrupt(returnFromInterrupt),
    .debugReturn(debugReturn), .statusWord(statusWord), .debugWindow(debugWindow)
);

// File: sim/test_cpu_register_set.sv
// Self-checking bench for the CPU register set: register file, PC, system registers, events.
// Assumes the pipeline model drives the system register port; other inputs come from here.
`timescale 1ns/100ps

module test_cpu_register_set;
    logic ref_clk = 1'b0, sys_rst = 1'b1, gprWrEn = 1'b0, shortMemAccess = 1'b0, pcLoad = 1'b0, pcIncr = 1'b0;
    logic maskableAccept = 1'b0, nmiAccept = 1'b0, debugTrapAccept = 1'b0, returnFromInterrupt = 1'b0;
    logic debugReturn = 1'b0, psWrEn = 1'b0, tableCallExec = 1'b0;
    logic [4:0] gprWrIdx = 5'h00, gprRdIdxA = 5'h00, gprRdIdxB = 5'h00;
    logic [2:0] pcIncrStep = 3'h4;
    logic [7:0] psWrData = 8'h00;
    logic [31:0] gprWrData = 32'h0000_0000, pcLoadValue = 32'h0000_0000, nextInstrPc = 32'h0000_0000;
    logic [31:0] causeCode = 32'h0000_0000;
    logic [31:0] gprRdDataA, gprRdDataB, pcValue, sysRdData, statusWord, sysWrData;
    logic sysRdValid, sysAccessDenied, debugWindow, sysWrEn, sysRdEn;
    logic [4:0] sysNum;
    int failures = 0, comparisons = 0, i;
    logic [4:0] nums [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h10, 5'h11, 5'h14};
    logic [31:0] exps [8] = '{32'h03ff_fffe, 32'h0000_00fe, 32'h03ff_fffe, 32'h0000_00fe, 32'h0000_00fe,
                              32'h03ff_fffe, 32'h0000_00fe, 32'hffff_fffe};

    always #25 ref_clk = ~ref_clk;

    crs_register_set i_crs_register_set (.ref_clk(ref_clk), .sys_rst(sys_rst), .gprWrEn(gprWrEn),
        .gprWrIdx(gprWrIdx), .gprWrData(gprWrData), .gprRdIdxA(gprRdIdxA), .gprRdIdxB(gprRdIdxB),
        .shortMemAccess(shortMemAccess), .gprRdDataA(gprRdDataA), .gprRdDataB(gprRdDataB), .pcLoad(pcLoad),
        .pcLoadValue(pcLoadValue), .pcIncr(pcIncr), .pcIncrStep(pcIncrStep), .pcValue(pcValue),
        .nextInstrPc(nextInstrPc), .psWrEn(psWrEn), .psWrData(psWrData), .sysWrEn(sysWrEn), .sysRdEn(sysRdEn),
        .sysNum(sysNum), .sysWrData(sysWrData), .sysRdData(sysRdData), .sysRdValid(sysRdValid),
        .sysAccessDenied(sysAccessDenied), .maskableAccept(maskableAccept), .nmiAccept(nmiAccept),
        .debugTrapAccept(debugTrapAccept), .tableCallExec(tableCallExec), .causeCode(causeCode),
        .returnFromInterrupt(returnFromInterrupt), .debugReturn(debugReturn), .statusWord(statusWord),
        .debugWindow(debugWindow));

    crs_pipe_model i_crs_pipe_model (.ref_clk(ref_clk), .sysRdData(sysRdData), .sysAccessDenied(sysAccessDenied),
        .sysWrEn(sysWrEn), .sysRdEn(sysRdEn), .sysNum(sysNum), .sysWrData(sysWrData));

    task tally_and_finish;
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task rdChk(input logic [4:0] num, input logic [31:0] exp, input logic expDenied);
        logic [31:0] data;
        logic denied;
        i_crs_pipe_model.sysRd(num, data, denied);
        chk(data, exp);
        chk({31'h0, denied}, {31'h0, expDenied});
    endtask

    task gprWr(input logic [4:0] idx, input logic [31:0] data);
        @(posedge ref_clk);
        gprWrEn <= 1'b1;
        gprWrIdx <= idx;
        gprWrData <= data;
        @(posedge ref_clk);
        gprWrEn <= 1'b0;
    endtask

    task gprChk(input logic [4:0] idx, input logic [31:0] exp);
        @(posedge ref_clk);
        gprRdIdxA <= idx;
        gprRdIdxB <= idx;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(gprRdDataA, exp);
        chk(gprRdDataB, exp);
    endtask

    // Kinds: 0 maskable, 1 NMI, 2 debug trap, 3 return, 4 debug return, 5 PC step, 6 PC load, 7 table call, 8 flags
    task evt(input int kind, input logic [31:0] v);
        @(posedge ref_clk);
        pcLoadValue <= v;
        nextInstrPc <= v;
        causeCode <= v;
        psWrData <= v[7:0];
        case (kind)
            0: maskableAccept <= 1'b1;
            1: nmiAccept <= 1'b1;
            2: debugTrapAccept <= 1'b1;
            3: returnFromInterrupt <= 1'b1;
            4: debugReturn <= 1'b1;
            5: pcIncr <= 1'b1;
            6: pcLoad <= 1'b1;
            7: tableCallExec <= 1'b1;
            default: psWrEn <= 1'b1;
        endcase
        @(posedge ref_clk);
        {maskableAccept, nmiAccept, debugTrapAccept, returnFromInterrupt, debugReturn} <= 5'h00;
        {pcIncr, pcLoad, tableCallExec, psWrEn} <= 4'h0;
        @(negedge ref_clk);
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        tally_and_finish;
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        chk(statusWord, 32'h0000_0020);
        chk(pcValue, 32'h0000_0000);
        gprWr(5'h00, 32'hffff_ffff);
        for (i = 1; i < 32; i++) gprWr(i[4:0], {i[7:0], 24'h5a_a5c3});
        gprChk(5'h00, 32'h0000_0000);
        for (i = 1; i < 32; i++) gprChk(i[4:0], {i[7:0], 24'h5a_a5c3});
        @(posedge ref_clk);
        shortMemAccess <= 1'b1;
        gprRdIdxA <= 5'h05;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(gprRdDataA, 32'h1e5a_a5c3);
        @(posedge ref_clk);
        shortMemAccess <= 1'b0;
        for (i = 0; i < 8; i++) begin
            i_crs_pipe_model.sysWr(nums[i], 32'hffff_fffe);
            rdChk(nums[i], exps[i], 1'b0);
        end
        i_crs_pipe_model.sysWr(5'h05, 32'h0000_0003);
        evt(6, 32'hffff_ffff);
        chk(pcValue, 32'h03ff_fffe);
        evt(5, 32'h0000_0000);
        chk(pcValue, 32'h0000_0002);
        evt(0, 32'hfc00_1005);
        rdChk(5'h00, 32'h0000_1004, 1'b0);
        rdChk(5'h01, 32'h0000_0003, 1'b0);
        rdChk(5'h04, 32'hfc00_1005, 1'b0);
        i_crs_pipe_model.sysWr(5'h04, 32'h0000_0000);
        rdChk(5'h04, 32'hfc00_1005, 1'b0);
        evt(1, 32'h0000_2008);
        chk(statusWord, 32'h0000_00a3);
        rdChk(5'h02, 32'h0000_2008, 1'b0);
        rdChk(5'h03, 32'h0000_0023, 1'b0);
        rdChk(5'h00, 32'h0000_1004, 1'b0);
        evt(3, 32'h0000_0000);
        chk(pcValue, 32'h0000_2008);
        chk(statusWord, 32'h0000_0023);
        i_crs_pipe_model.sysWr(5'h00, 32'h0000_3001);
        evt(3, 32'h0000_0000);
        chk(pcValue, 32'h0000_3000);
        chk(statusWord, 32'h0000_0003);
        rdChk(5'h12, 32'h0000_0000, 1'b1);
        evt(2, 32'h0000_4006);
        chk({31'h0, debugWindow}, 32'h0000_0001);
        rdChk(5'h12, 32'h0000_4006, 1'b0);
        rdChk(5'h13, 32'h0000_0003, 1'b0);
        evt(4, 32'h0000_0000);
        chk(pcValue, 32'h0000_4006);
        chk({31'h0, debugWindow}, 32'h0000_0000);
        evt(8, 32'h0000_0011);
        evt(7, 32'hfc00_5007);
        rdChk(5'h10, 32'h0000_5006, 1'b0);
        rdChk(5'h11, 32'h0000_0011, 1'b0);
        for (i = 6; i < 32; i++) if (i < 16 || i > 20) rdChk(i[4:0], 32'h0000_0000, 1'b1);
        tally_and_finish;
    end
endmodule
